/* File: mgt_pkg.sv */
// Shared constants and types of the management serial link
package mgt_pkg;
  // System clock and generated link clock
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         MDC_PERIOD_NS = 64;
  localparam int         MDC_HALF_CYC  = MDC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [1:0] MDC_DIV_LAST  = 2'(MDC_HALF_CYC - 1);
  // Frame fields
  localparam logic [5:0] IDLE_ONES     = 6'h20;
  localparam logic [1:0] START_PAT     = 2'h1;
  localparam logic [3:0] HDR_LAST      = 4'hb;
  localparam int         WORD_BITS     = 16;
  localparam int         NREGS         = 11;
  localparam logic [4:0] MULTI_ADDR    = 5'h1f;
  localparam logic [7:0] SINGLE_LAST   = 8'h0f;
  localparam logic [7:0] MULTI_LAST    = 8'haf;
  // Station bit positions counted from the first idle bit
  localparam logic [7:0] STA_PRE_LAST  = 8'h1f;
  localparam logic [7:0] STA_TA_POS    = 8'h2e;
  localparam logic [7:0] STA_DATA_POS  = 8'h30;
  // Register map: 0..5 and 16..20 are implemented
  localparam logic [4:0] REG_LO_LAST   = 5'h05;
  localparam logic [4:0] REG_HI_BASE   = 5'h10;
  localparam logic [4:0] REG_HI_LAST   = 5'h14;
  localparam logic [3:0] REG_HI_IDX    = 4'h6;
  localparam logic [3:0] REG_LAST_IDX  = 4'ha;
  // Link-side reset stretch in system clocks
  localparam logic [6:0] LRST_HOLD_CYC = 7'h40;

  typedef logic [NREGS-1:0][WORD_BITS-1:0] mgt_regs_t;
endpackage

/* File: mgt_link_if.sv */
// Management link between station and PHY with resolved data line
`timescale 1ns/10ps
interface mgt_link_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe_n;
  logic phy_mdio_o;
  logic phy_mdio_oe_n;
  logic mdio;

  // Line level; an undriven line is held high by the pull-up
  assign mdio = !sta_mdio_oe_n ? sta_mdio_o : (!phy_mdio_oe_n ? phy_mdio_o : 1'b1);

  modport station (
    output mdc,
    output sta_mdio_o,
    output sta_mdio_oe_n,
    input  mdio
  );

  modport phy (
    input  mdc,
    input  mdio,
    output phy_mdio_o,
    output phy_mdio_oe_n
  );
endinterface

/* File: mgt_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/10ps
module mgt_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    meta_q <= d;
    sync_q <= meta_q;
  end
endmodule

/* File: mgt_station_end.sv */
// Station end: makes the link clock and sends management frames
`timescale 1ns/10ps
module mgt_station_end (
  // System clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Link
  mgt_link_if.station             link,
  // Request
  input  wire logic               req,
  input  wire logic               req_rd,
  input  wire logic               req_multi,
  input  wire logic [4:0]         req_phy,
  input  wire logic [4:0]         req_reg,
  input  wire mgt_pkg::mgt_regs_t req_wdata,
  // Answer
  output logic                    busy_q,
  output logic                    done_q,
  output mgt_pkg::mgt_regs_t      rdata_q
);
  import mgt_pkg::*;

  logic [1:0]  div_q;
  logic        mdc_q;
  logic        fall;
  logic        mdio_s;
  logic [7:0]  k_q;
  logic [7:0]  last_q;
  logic [13:0] hdr_q;
  logic        rd_q;
  mgt_regs_t   wdata_q;
  logic        o_q;
  logic        oe_n_q;
  logic [7:0]  d_pos;

  assign link.mdc           = mdc_q;
  assign link.sta_mdio_o    = o_q;
  assign link.sta_mdio_oe_n = oe_n_q;
  assign fall  = (div_q == MDC_DIV_LAST) && mdc_q;
  assign d_pos = k_q - STA_DATA_POS;

  // Line input crosses into the system clock
  mgt_sync #(.W(1)) u_in_sync (
    .clk    (clk),
    .d      (link.mdio),
    .sync_q (mdio_s)
  );

  // Link clock divider; line changes only when the clock falls
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
      mdc_q <= 1'b1;
    end else begin
      div_q <= (div_q == MDC_DIV_LAST) ? 2'h0 : div_q + 2'h1;
      if (div_q == MDC_DIV_LAST) begin
        mdc_q <= ~mdc_q;
      end
    end
  end

  // Request capture and frame bit counter
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      k_q     <= 8'h00;
      last_q  <= 8'h00;
      hdr_q   <= 14'h0000;
      rd_q    <= 1'b0;
      wdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (req && !busy_q) begin
        busy_q  <= 1'b1;
        k_q     <= 8'h00;
        rd_q    <= req_rd;
        wdata_q <= req_wdata;
        hdr_q   <= {START_PAT, req_rd, !req_rd, req_phy, req_reg};
        last_q  <= STA_DATA_POS + ((req_multi && req_reg == MULTI_ADDR) ?
                                   MULTI_LAST : SINGLE_LAST);
      end else if (busy_q && fall) begin
        k_q <= k_q + 8'h01;
        if (k_q > STA_PRE_LAST && k_q < STA_TA_POS) begin
          hdr_q <= {hdr_q[12:0], 1'b0};
        end
        if (k_q == last_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // Line drive per frame position
  always_ff @(posedge clk) begin
    if (rst) begin
      o_q    <= 1'b1;
      oe_n_q <= 1'b1;
    end else if (fall) begin
      if (!busy_q) begin
        o_q    <= 1'b1;
        oe_n_q <= 1'b1;
      end else if (k_q <= STA_PRE_LAST) begin
        o_q    <= 1'b1;
        oe_n_q <= 1'b0;
      end else if (k_q < STA_TA_POS) begin
        o_q    <= hdr_q[13];
        oe_n_q <= 1'b0;
      end else if (rd_q) begin
        o_q    <= 1'b1;
        oe_n_q <= 1'b1;
      end else if (k_q < STA_DATA_POS) begin
        o_q    <= (k_q == STA_TA_POS);
        oe_n_q <= 1'b0;
      end else begin
        o_q    <= wdata_q[d_pos[7:4]][4'hf - d_pos[3:0]];
        oe_n_q <= 1'b0;
      end
    end
  end

  // Read data capture, most significant bit first
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (fall && busy_q && rd_q && k_q >= STA_DATA_POS) begin
      rdata_q[d_pos[7:4]] <= {rdata_q[d_pos[7:4]][14:0], mdio_s};
    end
  end
endmodule

/* File: mgt_phy_end.sv */
// PHY end: management frame decoder, register store and turnaround control
`timescale 1ns/10ps
module mgt_phy_end (
  // System clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Link
  mgt_link_if.phy            link,
  // Configuration
  input  wire logic [4:0]    own_addr,
  input  wire logic          multi_en,
  // Register view in system clock
  output mgt_pkg::mgt_regs_t regs_view_q,
  output logic               upd_q
);
  import mgt_pkg::*;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_START,
    ST_HDR,
    ST_TA1,
    ST_TA0,
    ST_DATA
  } mgt_phy_state_t;

  mgt_phy_state_t st_q;
  logic           lrst;
  logic [5:0]     cfg_l;
  logic [6:0]     hold_q;
  logic           lrst_req_q;
  logic [5:0]     ones_q;
  logic [3:0]     hcnt_q;
  logic [10:0]    hdr_q;
  logic [11:0]    hdr_full;
  logic [4:0]     dec;
  logic           hdr_go;
  logic [7:0]     cnt_q;
  logic [7:0]     last_bit;
  logic           fin;
  logic           rd_q;
  logic           multi_q;
  logic [3:0]     idx_q;
  logic           idx_ok_q;
  logic [15:0]    out_sr_q;
  logic [15:0]    in_sr_q;
  logic [15:0]    in_word;
  logic [15:0]    next_word;
  logic           mdio_o_q;
  logic           mdio_oe_n_q;
  mgt_regs_t      regs_q;
  mgt_regs_t      stage_q;
  logic [10:0]    wmask_q;
  logic           commit_q;
  logic           tgl_q;
  logic           tgl_s;
  logic           tgl_seen_q;

  // Maps a register address to {implemented, store index}
  function automatic logic [4:0] reg_index(input logic [4:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a <= REG_LO_LAST) begin
      r = {1'b1, a[3:0]};
    end else if (a >= REG_HI_BASE && a <= REG_HI_LAST) begin
      r = {1'b1, a[3:0] + REG_HI_IDX};
    end
    return r;
  endfunction

  // Frame decode terms
  assign hdr_full  = {hdr_q, link.mdio};
  assign dec       = reg_index(hdr_full[4:0]);
  assign hdr_go    = (st_q == ST_HDR) && (hcnt_q == HDR_LAST)
                     && (hdr_full[11] ^ hdr_full[10])
                     && (hdr_full[9:5] == cfg_l[4:0])
                     && (hdr_full[4:0] != MULTI_ADDR || cfg_l[5]);
  assign last_bit  = multi_q ? MULTI_LAST : SINGLE_LAST;
  assign fin       = (st_q == ST_DATA) && (cnt_q == last_bit);
  assign in_word   = {in_sr_q[14:0], link.mdio};
  assign next_word = regs_q[cnt_q[7:4] + 4'h1];

  assign link.phy_mdio_o    = mdio_o_q;
  assign link.phy_mdio_oe_n = mdio_oe_n_q;

  // Link-side reset is stretched so it spans link clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q     <= LRST_HOLD_CYC;
      lrst_req_q <= 1'b1;
    end else begin
      if (hold_q != 7'h00) begin
        hold_q <= hold_q - 7'h01;
      end
      lrst_req_q <= (hold_q != 7'h00);
    end
  end

  // Reset and configuration levels into the link clock
  mgt_sync #(.W(1)) u_rst_sync (
    .clk    (link.mdc),
    .d      (lrst_req_q),
    .sync_q (lrst)
  );

  mgt_sync #(.W(6)) u_cfg_sync (
    .clk    (link.mdc),
    .d      ({multi_en, own_addr}),
    .sync_q (cfg_l)
  );

  // Frame sequencer on the rising link clock
  always_ff @(posedge link.mdc) begin
    if (lrst) begin
      st_q     <= ST_HUNT;
      ones_q   <= 6'h00;
      hcnt_q   <= 4'h0;
      hdr_q    <= 11'h000;
      cnt_q    <= 8'h00;
      rd_q     <= 1'b0;
      multi_q  <= 1'b0;
      idx_q    <= 4'h0;
      idx_ok_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_HUNT: begin
          if (link.mdio) begin
            if (ones_q != IDLE_ONES) begin
              ones_q <= ones_q + 6'h01;
            end
          end else if (ones_q == IDLE_ONES) begin
            st_q <= ST_START;
          end else begin
            ones_q <= 6'h00;
          end
        end
        ST_START: begin
          ones_q <= 6'h00;
          hcnt_q <= 4'h0;
          st_q   <= (link.mdio == START_PAT[0]) ? ST_HDR : ST_HUNT;
        end
        ST_HDR: begin
          hdr_q  <= hdr_full[10:0];
          hcnt_q <= hcnt_q + 4'h1;
          if (hcnt_q == HDR_LAST) begin
            st_q     <= hdr_go ? ST_TA1 : ST_HUNT;
            rd_q     <= hdr_full[11];
            multi_q  <= (hdr_full[4:0] == MULTI_ADDR);
            idx_q    <= dec[3:0];
            idx_ok_q <= dec[4];
          end
        end
        ST_TA1: begin
          st_q <= ST_TA0;
        end
        ST_TA0: begin
          cnt_q <= 8'h00;
          st_q  <= (!rd_q && link.mdio) ? ST_HUNT : ST_DATA;
        end
        ST_DATA: begin
          cnt_q <= cnt_q + 8'h01;
          if (fin) begin
            st_q <= ST_HUNT;
          end
        end
      endcase
    end
  end

  // Read drive: turnaround zero, then data most significant bit first
  always_ff @(posedge link.mdc) begin
    if (lrst) begin
      mdio_o_q    <= 1'b1;
      mdio_oe_n_q <= 1'b1;
      out_sr_q    <= 16'h0000;
    end else begin
      if (hdr_go) begin
        out_sr_q <= hdr_full[4:0] == MULTI_ADDR ? regs_q[0] :
                    (dec[4] ? regs_q[dec[3:0]] : 16'h0000);
      end else if (st_q == ST_TA1 && rd_q) begin
        mdio_o_q    <= 1'b0;
        mdio_oe_n_q <= 1'b0;
      end else if (st_q == ST_TA0 && rd_q) begin
        mdio_o_q <= out_sr_q[15];
        out_sr_q <= {out_sr_q[14:0], 1'b0};
      end else if (st_q == ST_DATA && rd_q) begin
        if (fin) begin
          mdio_o_q    <= 1'b1;
          mdio_oe_n_q <= 1'b1;
        end else if (cnt_q[3:0] == 4'hf) begin
          mdio_o_q <= next_word[15];
          out_sr_q <= {next_word[14:0], 1'b0};
        end else begin
          mdio_o_q <= out_sr_q[15];
          out_sr_q <= {out_sr_q[14:0], 1'b0};
        end
      end else begin
        mdio_oe_n_q <= 1'b1;
      end
    end
  end

  // Write capture into a staging copy; nothing lands before the end
  always_ff @(posedge link.mdc) begin
    if (lrst) begin
      in_sr_q  <= 16'h0000;
      stage_q  <= '0;
      wmask_q  <= 11'h000;
      commit_q <= 1'b0;
    end else begin
      commit_q <= fin && !rd_q;
      if (hdr_go) begin
        wmask_q <= 11'h000;
      end
      if (st_q == ST_DATA && !rd_q) begin
        in_sr_q <= in_word;
        if (cnt_q[3:0] == 4'hf) begin
          if (multi_q) begin
            stage_q[cnt_q[7:4]] <= in_word;
            wmask_q[cnt_q[7:4]] <= 1'b1;
          end else if (idx_ok_q) begin
            stage_q[idx_q] <= in_word;
            wmask_q[idx_q] <= 1'b1;
          end
        end
      end
    end
  end

  // Register store updated once per write frame
  always_ff @(posedge link.mdc) begin
    if (lrst) begin
      regs_q <= '0;
      tgl_q  <= 1'b0;
    end else begin
      tgl_q <= tgl_q ^ commit_q;
      for (int k = 0; k <= int'(REG_LAST_IDX); k++) begin
        if (commit_q && wmask_q[k]) begin
          regs_q[k] <= stage_q[k];
        end
      end
    end
  end

  // Commit event crosses as a toggle; the store is stable when copied
  mgt_sync #(.W(1)) u_tgl_sync (
    .clk    (clk),
    .d      (tgl_q),
    .sync_q (tgl_s)
  );

  // Register view and update pulse in the system clock
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_seen_q  <= 1'b0;
      upd_q       <= 1'b0;
      regs_view_q <= '0;
    end else begin
      tgl_seen_q <= tgl_s;
      upd_q      <= tgl_s ^ tgl_seen_q;
      if (tgl_s ^ tgl_seen_q) begin
        regs_view_q <= regs_q;
      end
    end
  end
endmodule

/* File: mgt_link_chk.sv */
// Concurrent checks on the management link wires
`timescale 1ns/10ps
module mgt_link_chk (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe_n,
  input wire logic phy_mdio_o,
  input wire logic phy_mdio_oe_n,
  input wire logic mdio
);
  logic [10:0] drv_q;
  logic [5:0]  ones_q;
  logic        arm_q;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Length of each PHY drive spell in system clocks
  always_ff @(posedge clk) begin
    if (rst || phy_mdio_oe_n) drv_q <= 11'h000;
    else drv_q <= drv_q + 11'h001;
  end

  // Run of ones at link clock rises, saturating at a full idle pattern
  // An unsettled line counts as a break, so the run never turns unknown
  always_ff @(posedge clk) begin
    if (rst) begin
      ones_q <= 6'h00;
    end else if ($rose(mdc)) begin
      if (mdio) begin
        if (ones_q != 6'h20) ones_q <= ones_q + 6'h01;
      end else begin
        ones_q <= 6'h00;
      end
    end
  end

  // Armed by a zero after a full idle pattern, spent when the PHY lets go
  always_ff @(posedge clk) begin
    if (rst || $rose(phy_mdio_oe_n)) arm_q <= 1'b0;
    else if ($rose(mdc) && !mdio && ones_q == 6'h20) arm_q <= 1'b1;
  end

  property p_no_clash; !(!sta_mdio_oe_n && !phy_mdio_oe_n); endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the line");
  property p_ta_zero; $fell(phy_mdio_oe_n) |-> !phy_mdio_o && !mdio; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("PHY first bit not zero");
  property p_ta_gap; $fell(phy_mdio_oe_n) |-> $past(sta_mdio_oe_n, 1) && $past(sta_mdio_oe_n, 3);
  endproperty
  a_ta_gap: assert property (p_ta_gap) else $error("no idle gap before PHY drives");
  // A real release only: the enable settling out of its unknown start is not a spell end
  property p_drv_len; !$past(phy_mdio_oe_n) && phy_mdio_oe_n |-> drv_q == 11'h088 || drv_q == 11'h588;
  endproperty
  a_drv_len: assert property (p_drv_len) else $error("PHY drive spell length wrong");
  property p_phy_on_rise; $changed(phy_mdio_oe_n) || $changed(phy_mdio_o) |-> $rose(mdc);
  endproperty
  a_phy_on_rise: assert property (p_phy_on_rise) else $error("PHY output off its edge");
  property p_sta_on_fall; $changed(sta_mdio_oe_n) || $changed(sta_mdio_o) |-> $fell(mdc);
  endproperty
  a_sta_on_fall: assert property (p_sta_on_fall) else $error("station output off its edge");
  property p_armed; $fell(phy_mdio_oe_n) |-> arm_q; endproperty
  a_armed: assert property (p_armed) else $error("PHY answered without idle pattern");
  property p_rest; $rose(phy_mdio_oe_n) |=> phy_mdio_oe_n [*8]; endproperty
  a_rest: assert property (p_rest) else $error("PHY drives again too soon");

  // Main traffic seen
  c_read: cover property ($fell(phy_mdio_oe_n));
  c_multi: cover property ($rose(phy_mdio_oe_n) && drv_q == 11'h588);
  c_frame: cover property ($fell(sta_mdio_oe_n));
endmodule

/* File: phy_mgmt_serial_frame_test.sv */
// Testbench joining station and PHY ends across the management link
`timescale 1ns/10ps
module phy_mgmt_serial_frame_test;
  import mgt_pkg::*;
  typedef struct packed {
    logic       rd;
    logic [4:0] ra;
    logic [3:0] slot;
    logic [15:0] wd;
  } mgt_tb_row_t;
  localparam logic [4:0] OWN_ADDR = 5'h0a;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        req = 1'b0;
  logic        req_rd = 1'b0;
  logic        req_multi = 1'b0;
  logic [4:0]  req_phy = 5'h00;
  logic [4:0]  req_reg = 5'h00;
  mgt_regs_t   req_wdata = '0;
  logic        multi_en = 1'b1;
  logic        busy_q;
  logic        done_q;
  mgt_regs_t   rdata_q;
  mgt_regs_t   regs_view_q;
  logic        upd_q;
  mgt_regs_t   exp_regs = '0;
  mgt_regs_t   wd;
  mgt_tb_row_t r;
  int          n_fail = 0;
  int          tests_run = 0;
  int          upd_cnt = 0;
  int          u;
  mgt_tb_row_t rows [10] = '{
    '{1'b0, 5'h00, 4'h0, 16'ha5c3}, '{1'b0, 5'h05, 4'h5, 16'h0001},
    '{1'b0, 5'h10, 4'h6, 16'h8000}, '{1'b0, 5'h14, 4'ha, 16'hffff},
    '{1'b0, 5'h15, 4'hf, 16'h5a5a}, '{1'b1, 5'h00, 4'h0, 16'ha5c3},
    '{1'b1, 5'h14, 4'ha, 16'hffff}, '{1'b1, 5'h10, 4'h6, 16'h8000},
    '{1'b1, 5'h05, 4'h5, 16'h0001}, '{1'b1, 5'h1e, 4'hf, 16'h0000}};

  mgt_link_if link ();
  mgt_station_end mgt_station_end_i (.clk(clk), .rst(rst), .link(link), .req(req),
    .req_rd(req_rd), .req_multi(req_multi), .req_phy(req_phy), .req_reg(req_reg),
    .req_wdata(req_wdata), .busy_q(busy_q), .done_q(done_q), .rdata_q(rdata_q));
  mgt_phy_end mgt_phy_end_i (.clk(clk), .rst(rst), .link(link), .own_addr(OWN_ADDR),
    .multi_en(multi_en), .regs_view_q(regs_view_q), .upd_q(upd_q));
  mgt_link_chk mgt_link_chk_i (.clk(clk), .rst(rst), .mdc(link.mdc),
    .sta_mdio_o(link.sta_mdio_o), .sta_mdio_oe_n(link.sta_mdio_oe_n),
    .phy_mdio_o(link.phy_mdio_o), .phy_mdio_oe_n(link.phy_mdio_oe_n), .mdio(link.mdio));

  // System clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Count register view updates
  always @(posedge clk) begin
    if (upd_q === 1'b1) upd_cnt <= upd_cnt + 1;
  end

  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [175:0] exp, input logic [175:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One frame from request to done, then time for the view to settle
  task automatic frame(input logic rd, input logic mu, input logic [4:0] pa,
                       input logic [4:0] ra, input mgt_regs_t wdat);
    int k;
    req_rd = rd;
    req_multi = mu;
    req_phy = pa;
    req_reg = ra;
    req_wdata = wdat;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    check("busy", 1'b1, busy_q);
    k = 0;
    while (done_q !== 1'b1 && k < 2200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2200) n_fail++;
    repeat (24) @(negedge clk);
    check("idle", 1'b0, busy_q);
  endtask

  // Hang guard
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (120) @(negedge clk);
    // Single-register rows, back to back
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      wd = '0;
      wd[0] = r.wd;
      u = upd_cnt;
      frame(r.rd, 1'b0, OWN_ADDR, r.ra, wd);
      if (r.rd) check("read word", r.wd, rdata_q[0]);
      else begin
        if (r.slot != 4'hf) begin
          exp_regs[r.slot] = r.wd;
          check("update count", u + 1, upd_cnt);
        end
        check("register view", exp_regs, regs_view_q);
      end
    end
    // Multi-register write, then read back all eleven words
    for (int k = 0; k < 11; k++) wd[k] = 16'h1000 + 16'(k) * 16'h0111;
    exp_regs = wd;
    frame(1'b0, 1'b1, OWN_ADDR, MULTI_ADDR, wd);
    check("multi view", exp_regs, regs_view_q);
    frame(1'b1, 1'b1, OWN_ADDR, MULTI_ADDR, '0);
    check("multi read", exp_regs, rdata_q);
    // Foreign address: write dropped, read sees the pulled-up line
    frame(1'b0, 1'b0, OWN_ADDR ^ 5'h01, 5'h00, '0);
    check("foreign write", exp_regs, regs_view_q);
    frame(1'b1, 1'b0, OWN_ADDR ^ 5'h01, 5'h00, '0);
    check("foreign read", 16'hffff, rdata_q[0]);
    // All-register address refused while multi mode is off
    multi_en = 1'b0;
    frame(1'b1, 1'b1, OWN_ADDR, MULTI_ADDR, '0);
    check("refused multi", {11{16'hffff}}, rdata_q);
    // Second reset clears the register view and leaves the line free
    rst = 1'b1;
    repeat (16) @(negedge clk);
    check("reset view", 176'h0, regs_view_q);
    check("reset line", 1'b1, link.mdio);
    check("reset busy", 1'b0, busy_q);
    rst = 1'b0;
    finish_test();
  end
endmodule
